// *** design/can_irq_consts.vh ***
// constants for the interrupt flag logic of the can controller core
// assumes a single 200 MHz clock and a simple word-indexed register port
//
// How it works
// - all flags merge onto one interrupt output
// - output high when flag and enable both set
// - set beats clear in the same cycle
// - flag register read-only, writes change nothing
// - bit 11 set on wake from sleep
// - bit 10 set on entering sleep
// - bit 9 set on entering bus-off
// - bit 8 set on any frame error
// - bit 7 shows receive queue non-empty
// - bit 6 set on receive queue overrun
// - bit 5 set on empty-queue read
// - bit 4 set on good frame stored
// - bit 3 set while priority buffer full
// - bit 2 set while transmit queue full
// - bit 1 set on frame sent ok
// - bit 0 set on arbitration loss
// - core disable clears flags 11,10,9,8,6,4,1,0
// - loopback sets received flag before sent flag
// - enable register read/write, resets to zero
// - acknowledge register write-one-to-clear, write-only
`ifndef CAN_IRQ_CONSTS_VH
`define CAN_IRQ_CONSTS_VH

// register word indices on the register port
`define PEND_FLAGS_IDX    2'h0
`define IRQ_ENABLES_IDX   2'h1
`define IRQ_ACK_IDX       2'h2

// field layout
`define FLAG_COUNT        12
`define FLAG_MSB          11
`define WAKE_BIT          11
`define DOZE_BIT          10
`define BUS_OFF_BIT       9
`define FRAME_ERR_BIT     8
`define RX_NONEMPTY_BIT   7
`define RX_OVERRUN_BIT    6
`define RX_UNDERRUN_BIT   5
`define RX_OK_BIT         4
`define PRIO_FULL_BIT     3
`define TX_FULL_BIT       2
`define TX_OK_BIT         1
`define ARB_LOSS_BIT      0

// flags cleared by a core disable write
`define DISABLE_CLR_MASK  12'h0f53

// reset values
`define FLAGS_RESET       12'h0000
`define ENABLES_RESET     12'h0000
`define RDATA_RESET       32'h0000_0000
`define RESERVED_ZERO     20'h0_0000

`endif

// *** design/sticky_flag_cell.v ***
// one sticky interrupt flag with set priority over clear
// assumes set, clear and disable strobes are synchronous to sys_clk
`timescale 1ns/1ps
module sticky_flag_cell #(
  parameter CLR_ON_DISABLE = 1'b1       // 1: core disable clears this flag
) (
  input  wire sys_clk,                  // system clock
  input  wire resetn,                   // synchronous reset, active low
  input  wire set_evt,                  // set condition, pulse or level
  input  wire ack_clr,                  // acknowledge write with 1 here
  input  wire disable_clr,              // core disable write pulse
  output reg  flag_q                    // sticky flag
);

  wire clr_any;

  // disable only reaches flags built to follow it
  assign clr_any = ack_clr | (disable_clr & CLR_ON_DISABLE);

  // set tested first so a coincident clear cannot lose an event
  always @(posedge sys_clk) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_any) begin
      flag_q <= 1'b0;
    end
  end

endmodule // sticky_flag_cell

// *** design/can_interrupt_flag_logic.v ***
// interrupt flag, enable and acknowledge registers of the can core
// assumes event inputs come from the protocol engine, queues and mode
// logic on the same clock; the register port is word indexed with a
// single-cycle write strobe and a read strobe answered one cycle later
`timescale 1ns/1ps
`include "can_irq_consts.vh"
module can_interrupt_flag_logic (
  input  wire        sys_clk,                 // system clock, 200 MHz
  input  wire        resetn,                  // synchronous reset, active low
  // register port
  input  wire [1:0]  reg_idx,                 // register word index
  input  wire        reg_wr,                  // write strobe, one cycle
  input  wire        reg_rd,                  // read strobe, one cycle
  input  wire [31:0] reg_wdata,               // write data
  output reg  [31:0] reg_rdata_q,             // read data, one cycle after read
  output reg         reg_rvalid_q,            // read data valid pulse
  // core control
  input  wire        core_disable_wr,         // pulse: 0 written to core_enable_bit
  input  wire        loopback_mode,           // level: internal loopback active
  // event sources
  input  wire        wake_evt,                // pulse: left sleep for normal
  input  wire        doze_evt,                // pulse: entered sleep
  input  wire        bus_off_evt,             // pulse: entered bus-off
  input  wire        frame_err_evt,           // pulse: protocol error seen
  input  wire        rx_queue_nonempty,       // level: receive queue holds data
  input  wire        rx_overrun_evt,          // pulse: frame lost, queue full
  input  wire        rx_underrun_evt,         // pulse: host read empty queue
  input  wire        rx_ok_evt,               // pulse: good frame stored
  input  wire        prio_buffer_full,        // level: priority buffer full
  input  wire        tx_queue_full,           // level: transmit queue full
  input  wire        tx_ok_evt,               // pulse: frame sent without error
  input  wire        arb_loss_evt,            // pulse: arbitration lost
  // interrupt
  output reg         irq_q,                   // merged interrupt, active high level
  output reg  [11:0] pending_q                // flag vector for status use
);

  // one-hot loopback ordering states
  localparam [1:0] LB_IDLE = 2'b01;
  localparam [1:0] LB_HOLD = 2'b10;

  // flags that follow a core disable write, one bit per flag
  localparam [11:0] DISABLE_MASK = `DISABLE_CLR_MASK;

  reg  [11:0] interrupt_enables_q;
  reg  [11:0] interrupt_enables_d;
  reg  [1:0]  lb_state_q;
  reg  [1:0]  lb_state_d;
  reg  [11:0] set_vec;
  reg  [11:0] ack_vec;
  reg         tx_ok_set;
  reg  [31:0] rdata_d;
  wire [11:0] interrupt_pending_flags;
  wire [11:0] flags_next;

  // decode strobes
  wire wr_en    = reg_wr & (reg_idx == `IRQ_ENABLES_IDX);
  wire wr_ack   = reg_wr & (reg_idx == `IRQ_ACK_IDX);

  // in loopback the sent flag trails the received flag by one cycle;
  // the looped frame reports both, so the hold state is the cheapest
  // way to keep the order visible to software
  always @* begin
    lb_state_d = lb_state_q;
    tx_ok_set  = 1'b0;
    case (lb_state_q)
      LB_IDLE: begin
        if (tx_ok_evt && loopback_mode) begin
          lb_state_d = LB_HOLD;
        end else begin
          tx_ok_set = tx_ok_evt;
        end
      end
      LB_HOLD: begin
        tx_ok_set  = 1'b1;
        lb_state_d = LB_IDLE;
      end
      default: begin
        lb_state_d = LB_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      lb_state_q <= LB_IDLE;
    end else begin
      lb_state_q <= lb_state_d;
    end
  end

  // map each source onto its flag position
  always @* begin
    set_vec = `FLAGS_RESET;
    set_vec[`WAKE_BIT]        = wake_evt;
    set_vec[`DOZE_BIT]        = doze_evt;
    set_vec[`BUS_OFF_BIT]     = bus_off_evt;
    set_vec[`FRAME_ERR_BIT]   = frame_err_evt;
    set_vec[`RX_NONEMPTY_BIT] = rx_queue_nonempty;
    set_vec[`RX_OVERRUN_BIT]  = rx_overrun_evt;
    set_vec[`RX_UNDERRUN_BIT] = rx_underrun_evt;
    set_vec[`RX_OK_BIT]       = rx_ok_evt;
    set_vec[`PRIO_FULL_BIT]   = prio_buffer_full;
    set_vec[`TX_FULL_BIT]     = tx_queue_full;
    set_vec[`TX_OK_BIT]       = tx_ok_set;
    set_vec[`ARB_LOSS_BIT]    = arb_loss_evt;
  end

  // acknowledge is write-one-to-clear; zeros and bits 31:12 do nothing,
  // and a write to the flag register itself never reaches the flags
  always @* begin
    ack_vec = `FLAGS_RESET;
    if (wr_ack) begin
      ack_vec = reg_wdata[`FLAG_MSB:0];
    end
  end

  // one cell per flag; the disable mask picks which follow core disable,
  // the rest only ever clear through an acknowledge write

  // wake: normal operation resumed after sleep
  // pulse source, sticky until acknowledged
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`WAKE_BIT])
  ) u_wake_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`WAKE_BIT]),
    .ack_clr     (ack_vec[`WAKE_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`WAKE_BIT])
  );

  // doze: sleep state entered
  // pulse source, sticky until acknowledged
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`DOZE_BIT])
  ) u_doze_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`DOZE_BIT]),
    .ack_clr     (ack_vec[`DOZE_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`DOZE_BIT])
  );

  // bus-off: fault confinement gave up the bus
  // pulse source, sticky until acknowledged
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`BUS_OFF_BIT])
  ) u_bus_off_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`BUS_OFF_BIT]),
    .ack_clr     (ack_vec[`BUS_OFF_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`BUS_OFF_BIT])
  );

  // frame error: any protocol error on a frame
  // several errors in a row collapse into one flag
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`FRAME_ERR_BIT])
  ) u_frame_err_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`FRAME_ERR_BIT]),
    .ack_clr     (ack_vec[`FRAME_ERR_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`FRAME_ERR_BIT])
  );

  // receive queue holds data; level source, so an
  // acknowledge only sticks once the queue drains
  // core disable leaves it alone
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`RX_NONEMPTY_BIT])
  ) u_rx_nonempty_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`RX_NONEMPTY_BIT]),
    .ack_clr     (ack_vec[`RX_NONEMPTY_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`RX_NONEMPTY_BIT])
  );

  // receive overrun: frame lost into a full queue
  // pulse source, sticky until acknowledged
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`RX_OVERRUN_BIT])
  ) u_rx_overrun_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`RX_OVERRUN_BIT]),
    .ack_clr     (ack_vec[`RX_OVERRUN_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`RX_OVERRUN_BIT])
  );

  // receive underrun: host read an empty queue
  // kept through core disable so software still
  // sees its own misuse afterwards
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`RX_UNDERRUN_BIT])
  ) u_rx_underrun_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`RX_UNDERRUN_BIT]),
    .ack_clr     (ack_vec[`RX_UNDERRUN_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`RX_UNDERRUN_BIT])
  );

  // good frame stored in the receive queue
  // in loopback this lands before the sent flag
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`RX_OK_BIT])
  ) u_rx_ok_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`RX_OK_BIT]),
    .ack_clr     (ack_vec[`RX_OK_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`RX_OK_BIT])
  );

  // priority buffer full; level source, further
  // writes to the full buffer do not touch it
  // core disable leaves it alone
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`PRIO_FULL_BIT])
  ) u_prio_full_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`PRIO_FULL_BIT]),
    .ack_clr     (ack_vec[`PRIO_FULL_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`PRIO_FULL_BIT])
  );

  // transmit queue full; level source, further
  // writes to the full queue do not touch it
  // core disable leaves it alone
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`TX_FULL_BIT])
  ) u_tx_full_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`TX_FULL_BIT]),
    .ack_clr     (ack_vec[`TX_FULL_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`TX_FULL_BIT])
  );

  // frame sent without error; fed through the
  // loopback ordering logic, not the raw pulse
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`TX_OK_BIT])
  ) u_tx_ok_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`TX_OK_BIT]),
    .ack_clr     (ack_vec[`TX_OK_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`TX_OK_BIT])
  );

  // arbitration lost while sending
  // the frame is retried, so this may fire often
  // also dropped by a core disable write
  sticky_flag_cell #(
    .CLR_ON_DISABLE (DISABLE_MASK[`ARB_LOSS_BIT])
  ) u_arb_loss_flag (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .set_evt     (set_vec[`ARB_LOSS_BIT]),
    .ack_clr     (ack_vec[`ARB_LOSS_BIT]),
    .disable_clr (core_disable_wr),
    .flag_q      (interrupt_pending_flags[`ARB_LOSS_BIT])
  );

  // next flag state mirrors the cell equation so irq tracks flags exactly
  assign flags_next = set_vec |
                      (interrupt_pending_flags & ~ack_vec &
                       ~({12{core_disable_wr}} & `DISABLE_CLR_MASK));

  // enable register, full read/write on the low twelve bits
  always @* begin
    interrupt_enables_d = interrupt_enables_q;
    if (wr_en) begin
      interrupt_enables_d = reg_wdata[`FLAG_MSB:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      interrupt_enables_q <= `ENABLES_RESET;
    end else begin
      interrupt_enables_q <= interrupt_enables_d;
    end
  end

  // single merged level, registered from next values so it rises in
  // the same cycle as the flag it reports
  always @(posedge sys_clk) begin
    if (!resetn) begin
      irq_q     <= 1'b0;
      pending_q <= `FLAGS_RESET;
    end else begin
      irq_q     <= |(flags_next & interrupt_enables_d);
      pending_q <= flags_next;
    end
  end

  // read mux; of the port's write paths only the acknowledge write reaches the flags
  always @* begin
    rdata_d = `RDATA_RESET;
    case (reg_idx)
      `PEND_FLAGS_IDX:  rdata_d = {`RESERVED_ZERO, interrupt_pending_flags};
      `IRQ_ENABLES_IDX: rdata_d = {`RESERVED_ZERO, interrupt_enables_q};
      `IRQ_ACK_IDX:     rdata_d = `RDATA_RESET;
      default:          rdata_d = `RDATA_RESET;
    endcase
  end

  // read answer one cycle after the strobe, zero otherwise
  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata_q  <= `RDATA_RESET;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end else begin
        reg_rdata_q <= `RDATA_RESET;
      end
    end
  end

endmodule // can_interrupt_flag_logic

// *** test/can_irq_flag_assertions.sv ***
// concurrent checks on the interrupt flag logic ports
// assumes one clock domain and the register index map of the design
`timescale 1ns/1ps
module can_irq_flag_checker (
  input wire        sys_clk,         // clock
  input wire        resetn,          // sync reset
  input wire [1:0]  reg_idx,         // index
  input wire        reg_wr,          // write strobe
  input wire        reg_rd,          // read strobe
  input wire [31:0] reg_wdata,       // write data
  input wire [31:0] reg_rdata_q,     // read data
  input wire        reg_rvalid_q,    // read valid
  input wire        core_disable_wr, // core disable
  input wire        loopback_mode,   // loopback
  input wire        rx_ok_evt,       // frame stored
  input wire        tx_ok_evt,       // frame sent
  input wire        arb_loss_evt,    // arbitration lost
  input wire        irq_q,           // interrupt
  input wire [11:0] pending_q        // flags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [11:0] en_q;
  wire         ack_w = reg_wr && reg_idx == 2'h2;
  // shadow of the enables, which have no port of their own
  always_ff @(posedge sys_clk)
    if (!resetn) en_q <= 12'h000;
    else if (reg_wr && reg_idx == 2'h1) en_q <= reg_wdata[11:0];
  irq_level_a: assert property (irq_q == |(pending_q & en_q))
    else $error("irq level wrong");
  set_wins_a: assert property (arb_loss_evt |=> pending_q[0])
    else $error("set lost");
  tx_normal_a: assert property (tx_ok_evt && !loopback_mode |=> pending_q[1])
    else $error("sent flag late");
  loop_order_a: assert property (tx_ok_evt && rx_ok_evt && loopback_mode && !pending_q[1]
    && !$past(tx_ok_evt) |=> pending_q[4] && !pending_q[1] ##1 pending_q[1])
    else $error("loopback order wrong");
  ack_clear_a: assert property (ack_w && reg_wdata[0] && !arb_loss_evt |=> !pending_q[0])
    else $error("ack did not clear");
  sticky_a: assert property (!ack_w && !core_disable_wr
    |=> (pending_q & $past(pending_q)) == $past(pending_q)) else $error("flag dropped");
  disable_clr_a: assert property (core_disable_wr && !tx_ok_evt && !rx_ok_evt &&
    !arb_loss_evt && !$past(tx_ok_evt) |=> (pending_q & 12'h013) == 12'h000)
    else $error("disable did not clear");
  rd_valid_a: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  rd_flags_a: assert property (reg_rd && reg_idx == 2'h0
    |=> reg_rdata_q == {20'h0_0000, $past(pending_q)}) else $error("flag read wrong");
  cover property (irq_q ##1 !irq_q);
  cover property (loopback_mode && tx_ok_evt && rx_ok_evt);
  cover property (core_disable_wr && |pending_q);
endmodule // can_irq_flag_checker
bind can_interrupt_flag_logic can_irq_flag_checker chk (.*);

// *** test/host_model.sv ***
// host processor side of the register port
// assumes strobes are taken at the rising edge after they rise
`timescale 1ns/1ps
module host_model (
  input  wire         sys_clk,             // clock
  output logic [1:0]  reg_idx = 2'h0,      // index
  output logic        reg_wr = 1'b0,       // write strobe
  output logic        reg_rd = 1'b0,       // read strobe
  output logic [31:0] reg_wdata = 32'h0000_0000 // write data
);
  // flags cleared through acknowledge writes of ones and by core disable
  task automatic wr(input logic [1:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    reg_idx <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // released data must not look valid
  endtask
  // one-cycle read strobe, answer checked by the bench model
  task automatic rd(input logic [1:0] i);
    @(posedge sys_clk);
    reg_idx <= i;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
endmodule // host_model

// *** test/tb.sv ***
// self-checking bench for the interrupt flag logic
// assumes the host model drives the register port
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        core_disable_wr = 1'b0;
  logic        loopback_mode = 1'b0;
  logic        rnd_on = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [31:0] r;
  wire  [1:0]  reg_idx;
  wire         reg_wr, reg_rd, reg_rvalid_q, irq_q;
  wire  [31:0] reg_wdata, reg_rdata_q;
  wire  [11:0] pending_q;
  int          fails = 0;
  int          checked = 0;
  int          mf, me, mrd, mrv, set, clr;
  bit          dly;
  host_model host (.sys_clk(sys_clk), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  can_interrupt_flag_logic DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_idx(reg_idx),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .core_disable_wr(core_disable_wr),
    .loopback_mode(loopback_mode), .wake_evt(ev[11]), .doze_evt(ev[10]), .bus_off_evt(ev[9]),
    .frame_err_evt(ev[8]), .rx_queue_nonempty(ev[7]), .rx_overrun_evt(ev[6]),
    .rx_underrun_evt(ev[5]), .rx_ok_evt(ev[4]), .prio_buffer_full(ev[3]),
    .tx_queue_full(ev[2]), .tx_ok_evt(ev[1]), .arb_loss_evt(ev[0]), .irq_q(irq_q),
    .pending_q(pending_q));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  // reference model, sees the same inputs the design samples
  always @(posedge sys_clk) begin
    if (!resetn) begin
      {mf, me, mrd, mrv, dly} = 0;
    end else begin
      mrv = reg_rd;
      mrd = !reg_rd ? 0 : reg_idx == 0 ? mf : reg_idx == 1 ? me : 0;
      set = {ev[11:2], (ev[1] && !loopback_mode) || dly, ev[0]}; // sent flag lags in loopback
      dly = ev[1] && loopback_mode && !dly; // a send in the hold cycle merges
      clr = (reg_wr && reg_idx == 2 ? reg_wdata[11:0] : 0) | (core_disable_wr ? 'hf53 : 0);
      mf = (mf & ~clr) | set;
      if (reg_wr && reg_idx == 1) me = reg_wdata[11:0];
    end
  end
  // compare every result away from the sampling edge
  always @(negedge sys_clk)
    if (resetn) begin
      `CHK("flags_hi", mf[11:8], pending_q[11:8])
      `CHK("flags_mid", mf[7:4], pending_q[7:4])
      `CHK("flags_lo", mf[3:0], pending_q[3:0])
      `CHK("irq", |(mf & me), irq_q)
      `CHK("rvalid", mrv[0], reg_rvalid_q)
      `CHK("rdata", mrd, reg_rdata_q)
    end
  // sparse random events during the random phase
  always @(posedge sys_clk)
    if (rnd_on) begin
      ev <= $urandom & $urandom & $urandom & $urandom;
      core_disable_wr <= ($urandom % 16) == 0;
      if (($urandom % 64) == 0) loopback_mode <= ~loopback_mode;
    end
  initial begin
    #100us;
    fails++;
    final_report;
  end
  initial begin
    r = $urandom(32'h652d_7341);
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) host.rd(i[1:0]);
    $display("test reset_values done");
    host.wr(2'h1, 32'hffff_ffff);
    loopback_mode <= 1'b1;
    ev <= 12'h012;
    @(posedge sys_clk);
    ev <= 12'h000;
    repeat (3) @(posedge sys_clk);
    $display("test loopback_order done");
    rnd_on <= 1'b1;
    repeat (3000) begin
      r = $urandom;
      if (r[0]) host.wr(r[2:1], $urandom);
      else host.rd(r[2:1]);
    end
    rnd_on <= 1'b0;
    $display("test random_traffic done");
    resetn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    host.rd(2'h0);
    host.rd(2'h1);
    $display("test second_reset done");
    final_report;
  end
endmodule // tb
